// *** ior_regs.svh ***
// register offsets, reset values and scaling limits of the output data bank
`ifndef IOR_REGS_SVH
`define IOR_REGS_SVH

`define IOR_ADDR_W          7
`define IOR_WORD_W          16
`define IOR_PAGE_ADDR       7'h00
`define IOR_PAGE_RESET      16'h0000
`define IOR_ACTIVE_PAGE     16'h0000
`define IOR_GYRO_X_FRACTION 7'h10
`define IOR_GYRO_X_WORD     7'h12
`define IOR_GYRO_Y_FRACTION 7'h14
`define IOR_GYRO_Y_WORD     7'h16
`define IOR_GYRO_Z_FRACTION 7'h18
`define IOR_GYRO_Z_WORD     7'h1a
`define IOR_ACCEL_X_FRACTION 7'h1c
`define IOR_ACCEL_X_WORD    7'h1e
`define IOR_ACCEL_Y_FRACTION 7'h20
`define IOR_ACCEL_Y_WORD    7'h22
`define IOR_ACCEL_Z_FRACTION 7'h24
`define IOR_ACCEL_Z_WORD    7'h26
`define IOR_UPPER_BIT       1
`define IOR_CHAN_LSB        2
`define IOR_FS_POS          16'h57e4
`define IOR_FS_NEG          16'ha81c
`define IOR_FRACTION_ZERO   16'h0000
`define IOR_READ_ZERO       16'h0000

`endif

// *** ior_pkg.sv ***
// shared types of the inertial output data bank
package ior_pkg;

    // one three-axis result, each axis 32-bit two's complement
    typedef struct packed {
        logic [31:0] x;
        logic [31:0] y;
        logic [31:0] z;
    } ior_axes_t;

    // one coherent sample of both sensors
    typedef struct packed {
        ior_axes_t gyro;
        ior_axes_t accel;
    } ior_sample_t;

    // host register access request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [6:0]  addr;
        logic [15:0] wdata;
    } ior_req_t;

endpackage

// *** ior_output_regs.sv ***
// page-0 inertial output data registers with page select and read port
`include "ior_regs.svh"

// Overview of operation
// - page select reads zero after start-up
// - sensor outputs only visible on page zero
// - results are 32-bit, upper and lower words
// - gyro word: 0.02 deg/s per count
// - gyro full scale reads 0x57e4 / 0xa81c
// - gyro fraction msb weighs 0.01 deg/s
// - gyro words at 0x10 through 0x1a
// - accel word: 0.8 mg, saturates at 18 g
// - accel fraction msb weighs 0.4 mg
// - accel words at 0x1c through 0x26
// - accel outputs include static gravity
module ior_output_regs #(
    parameter int CHANNELS = 6
) (
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic                clkEn,
    input  wire logic                sampleValid,
    input  wire ior_pkg::ior_sample_t sampleIn,
    input  wire ior_pkg::ior_req_t   hostReq,
    output logic [15:0]              regRdata,
    output logic                     regRdValid,
    output logic [15:0]              pageSelect
);

    logic                rstnMeta;
    logic                rstnSync;
    logic [31:0]         chanIn   [CHANNELS];
    logic [31:0]         dataReg  [CHANNELS];
    logic [31:0]         next_data[CHANNELS];
    logic                inData;
    logic                onPage0;
    logic                pageHit;
    logic [2:0]          chanSel;
    logic                upperSel;
    logic [31:0]         selWord;
    logic [15:0]         next_rdata;

    // reset release through two flops
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rstnMeta <= 1'b0;
            rstnSync <= 1'b0;
        end else begin
            rstnMeta <= 1'b1;
            rstnSync <= rstnMeta;
        end
    end

    // channel order follows the address map: gyro x,y,z then accel x,y,z
    assign chanIn[0] = sampleIn.gyro.x;
    assign chanIn[1] = sampleIn.gyro.y;
    assign chanIn[2] = sampleIn.gyro.z;
    assign chanIn[3] = sampleIn.accel.x;
    assign chanIn[4] = sampleIn.accel.y;
    assign chanIn[5] = sampleIn.accel.z;  // gravity passes through

    // clamp the upper word to the documented full-scale codes
    function automatic logic [31:0] clampFs(input logic [31:0] v);
        logic signed [15:0] up;
        up = v[31:16];
        if (up > $signed(`IOR_FS_POS)) begin
            clampFs = {`IOR_FS_POS, `IOR_FRACTION_ZERO};
        end else if (up < $signed(`IOR_FS_NEG)) begin
            clampFs = {`IOR_FS_NEG, `IOR_FRACTION_ZERO};
        end else begin
            clampFs = v;  // two's complement kept
        end
    endfunction

    // per channel 32-bit store, both halves loaded on one edge
    for (genvar i = 0; i < CHANNELS; i++) begin : gChan
        assign next_data[i] = sampleValid ? clampFs(chanIn[i]) : dataReg[i];
        always_ff @(posedge core_clk or negedge rstnSync) begin
            if (!rstnSync) begin
                dataReg[i] <= '0;
            end else if (clkEn) begin
                dataReg[i] <= next_data[i];
            end
        end
    end

    // address decode for the read port
    assign inData   = (hostReq.addr >= `IOR_GYRO_X_FRACTION)
                   && (hostReq.addr <= `IOR_ACCEL_Z_WORD);
    assign onPage0  = (pageSelect == `IOR_ACTIVE_PAGE);
    assign pageHit  = (hostReq.addr == `IOR_PAGE_ADDR);
    assign chanSel  = 3'((hostReq.addr - `IOR_GYRO_X_FRACTION) >> `IOR_CHAN_LSB);
    assign upperSel = hostReq.addr[`IOR_UPPER_BIT];
    assign selWord  = inData ? dataReg[chanSel] : '0;

    // read data selection: page select on every page, data on page 0 only
    always_comb begin
        next_rdata = `IOR_READ_ZERO;
        if (pageHit) begin
            next_rdata = pageSelect;
        end else if (inData && onPage0) begin
            next_rdata = upperSel ? selWord[31:16]
                                  : selWord[15:0];
        end
    end

    // page select register, zero after reset
    always_ff @(posedge core_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            pageSelect <= `IOR_PAGE_RESET;
        end else if (clkEn && hostReq.wr && pageHit) begin
            pageSelect <= hostReq.wdata;
        end
    end

    // read answer one cycle after the strobe
    always_ff @(posedge core_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            regRdata   <= `IOR_READ_ZERO;
            regRdValid <= 1'b0;
        end else if (clkEn) begin
            regRdValid <= hostReq.rd;
            if (hostReq.rd) begin
                regRdata <= next_rdata;
            end
        end
    end

    // checks on the design's own behaviour
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstnSync);

    property p_page_reset;
        !$past(rstnSync) ##0 rstnSync |-> pageSelect == `IOR_PAGE_RESET;
    endproperty
    a_page_reset: assert property (p_page_reset)
        else $error("page select not zero after reset");

    property p_off_page;
        clkEn && hostReq.rd && inData && !onPage0
            |=> regRdValid && regRdata == `IOR_READ_ZERO;
    endproperty
    a_off_page: assert property (p_off_page)
        else $error("data visible off page zero");

    property p_upper_word;
        logic [15:0] up;
        (clkEn && hostReq.rd && inData && onPage0 && upperSel,
         up = selWord[31:16]) |=> regRdata == up;
    endproperty
    a_upper_word: assert property (p_upper_word)
        else $error("upper word read wrong");

    property p_lower_word;
        logic [15:0] lo;
        (clkEn && hostReq.rd && inData && onPage0 && !upperSel,
         lo = selWord[15:0]) |=> regRdata == lo;
    endproperty
    a_lower_word: assert property (p_lower_word)
        else $error("fraction word read wrong");

    property p_gyro_pass;
        clkEn && sampleValid
            && $signed(sampleIn.gyro.x[31:16]) <= $signed(`IOR_FS_POS)
            && $signed(sampleIn.gyro.x[31:16]) >= $signed(`IOR_FS_NEG)
            |=> dataReg[0] == $past(sampleIn.gyro.x);
    endproperty
    a_gyro_pass: assert property (p_gyro_pass)
        else $error("in-range gyro value altered");

    property p_gyro_pos_sat;
        clkEn && sampleValid
            && $signed(sampleIn.gyro.y[31:16]) > $signed(`IOR_FS_POS)
            |=> dataReg[1][31:16] == `IOR_FS_POS
                && dataReg[1][15:0] == `IOR_FRACTION_ZERO;
    endproperty
    a_gyro_pos_sat: assert property (p_gyro_pos_sat)
        else $error("gyro positive full scale wrong");

    property p_accel_neg_sat;
        clkEn && sampleValid
            && $signed(sampleIn.accel.x[31:16]) < $signed(`IOR_FS_NEG)
            |=> dataReg[3][31:16] == `IOR_FS_NEG;
    endproperty
    a_accel_neg_sat: assert property (p_accel_neg_sat)
        else $error("accel negative full scale wrong");

    property p_gyro_z_map;
        logic [15:0] w;
        (clkEn && hostReq.rd && onPage0 && hostReq.addr == `IOR_GYRO_Z_WORD,
         w = dataReg[2][31:16]) |=> regRdValid && regRdata == w;
    endproperty
    a_gyro_z_map: assert property (p_gyro_z_map)
        else $error("gyro z word at wrong address");

    property p_accel_z_map;
        logic [15:0] w;
        (clkEn && hostReq.rd && onPage0
         && hostReq.addr == `IOR_ACCEL_Z_FRACTION,
         w = dataReg[5][15:0]) |=> regRdata == w;
    endproperty
    a_accel_z_map: assert property (p_accel_z_map)
        else $error("accel z fraction at wrong address");

    property p_accel_static;
        clkEn && sampleValid
            && $signed(sampleIn.accel.z[31:16]) <= $signed(`IOR_FS_POS)
            && $signed(sampleIn.accel.z[31:16]) >= $signed(`IOR_FS_NEG)
            |=> dataReg[5] == $past(sampleIn.accel.z);
    endproperty
    a_accel_static: assert property (p_accel_static)
        else $error("accel z value not carried through");

    property p_coherent;
        !$past(clkEn && sampleValid) |-> $stable(dataReg[0])
            && $stable(dataReg[4]);
    endproperty
    a_coherent: assert property (p_coherent)
        else $error("data changed without a sample");

    property p_rd_valid;
        clkEn && hostReq.rd |=> regRdValid;
    endproperty
    a_rd_valid: assert property (p_rd_valid)
        else $error("read answer missing");

    // handshake, page, freeze and clamp checks
    property p_rd_single;
        clkEn && !hostReq.rd |=> !regRdValid;
    endproperty
    a_rd_single: assert property (p_rd_single)
        else $error("read answer without a read");

    property p_rd_hold;
        !(clkEn && hostReq.rd) |=> $stable(regRdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without a read");

    property p_page_write;
        clkEn && hostReq.wr && pageHit |=> pageSelect == $past(hostReq.wdata);
    endproperty
    a_page_write: assert property (p_page_write)
        else $error("page select write lost");

    property p_page_hold;
        !(clkEn && hostReq.wr && pageHit) |=> $stable(pageSelect);
    endproperty
    a_page_hold: assert property (p_page_hold)
        else $error("page select changed without a write");

    property p_page_read;
        clkEn && hostReq.rd && pageHit |=> regRdata == $past(pageSelect);
    endproperty
    a_page_read: assert property (p_page_read)
        else $error("page select read wrong");

    property p_unmapped;
        clkEn && hostReq.rd && !inData && !pageHit
            |=> regRdata == `IOR_READ_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address not zero");

    property p_freeze;
        !clkEn |=> $stable(pageSelect) && $stable(regRdata)
            && $stable(regRdValid) && $stable(dataReg[0]);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved with clock enable low");

    property p_reset_outputs;
        !$past(rstnSync) ##0 rstnSync |-> !regRdValid
            && regRdata == `IOR_READ_ZERO;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs)
        else $error("read port not quiet after reset");

    property p_gyro_neg_sat;
        clkEn && sampleValid
            && $signed(sampleIn.gyro.z[31:16]) < $signed(`IOR_FS_NEG)
            |=> dataReg[2][31:16] == `IOR_FS_NEG
                && dataReg[2][15:0] == `IOR_FRACTION_ZERO;
    endproperty
    a_gyro_neg_sat: assert property (p_gyro_neg_sat)
        else $error("gyro negative full scale wrong");

    property p_accel_pos_sat;
        clkEn && sampleValid
            && $signed(sampleIn.accel.y[31:16]) > $signed(`IOR_FS_POS)
            |=> dataReg[4][31:16] == `IOR_FS_POS
                && dataReg[4][15:0] == `IOR_FRACTION_ZERO;
    endproperty
    a_accel_pos_sat: assert property (p_accel_pos_sat)
        else $error("accel positive full scale wrong");

    property p_accel_pass;
        clkEn && sampleValid
            && $signed(sampleIn.accel.x[31:16]) <= $signed(`IOR_FS_POS)
            && $signed(sampleIn.accel.x[31:16]) >= $signed(`IOR_FS_NEG)
            |=> dataReg[3] == $past(sampleIn.accel.x);
    endproperty
    a_accel_pass: assert property (p_accel_pass)
        else $error("in-range accel value altered");

endmodule

// *** ior_host_model.sv ***
// host-side model issuing register requests and collecting read answers
module ior_host_model (
    input  wire logic         core_clk,
    output ior_pkg::ior_req_t hostReq,
    input  wire logic [15:0]  regRdata,
    input  wire logic         regRdValid
);
    timeunit 1ns;
    timeprecision 1ps;

    // quiet request at time zero
    initial hostReq = '0;

    // released strobes drop low, address and data lines show the inverse of their last value
    task automatic idle();
        hostReq <= '{1'b0, 1'b0, ~hostReq.addr, ~hostReq.wdata};
    endtask

    // one-cycle read, answer taken while the valid strobe stands
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        hostReq <= '{1'b1, 1'b0, a, 16'h0000};
        @(posedge core_clk);
        idle();
        #1;
        while (regRdValid !== 1'b1 && n < 4) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        d = (regRdValid === 1'b1) ? regRdata : 16'hxxxx;
    endtask

    // one-cycle write, no answer expected
    task automatic wr(input logic [6:0] a, input logic [15:0] w);
        @(posedge core_clk);
        hostReq <= '{1'b0, 1'b1, a, w};
        @(posedge core_clk);
        idle();
    endtask
endmodule

// *** tb_top.sv ***
// self-checking bench for the page-0 inertial output data bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 core_clk;
    logic                 rstn;
    logic                 clkEn;
    logic                 sampleValid;
    ior_pkg::ior_sample_t sampleIn;
    ior_pkg::ior_req_t    hostReq;
    logic [15:0]          regRdata;
    logic                 regRdValid;
    logic [15:0]          pageSelect;
    logic [15:0]          got;
    int                   fails;
    int                   checks;

    // block under test and the host facing it
    ior_output_regs ior_output_regs_i (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn),
        .sampleValid(sampleValid), .sampleIn(sampleIn), .hostReq(hostReq),
        .regRdata(regRdata), .regRdValid(regRdValid), .pageSelect(pageSelect));
    ior_host_model ior_host_model_i (.core_clk(core_clk), .hostReq(hostReq),
        .regRdata(regRdata), .regRdValid(regRdValid));

    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic report_and_stop();
        $display("fails %0d checks %0d", fails, checks);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask

    // read one register and compare
    task automatic rc(input string nm, input logic [6:0] a, input logic [15:0] e);
        ior_host_model_i.rd(a, got);
        chk(nm, e, got);
    endtask

    task automatic load(input ior_pkg::ior_sample_t s);
        @(posedge core_clk);
        sampleValid <= 1'b1;
        sampleIn    <= s;
        @(posedge core_clk);
        sampleValid <= 1'b0;
    endtask

    task automatic t_reset();
        chk("pageSelect", 16'h0000, pageSelect);
        rc("page", 7'h00, 16'h0000);
    endtask

    // distinct value per channel, every word at its offset
    task automatic t_map();
        ior_pkg::ior_sample_t s;
        for (int n = 0; n < 6; n++) begin
            s[191 - 32 * n -: 32] = {16'h1000 + 16'(n) * 16'h0111, 16'hc000 + 16'(n)};
        end
        load(s);
        for (int n = 0; n < 6; n++) begin
            rc("fraction", 7'h10 + 7'(4 * n), 16'hc000 + 16'(n));
            rc("word", 7'h12 + 7'(4 * n), 16'h1000 + 16'(n) * 16'h0111);
        end
    endtask

    // full scale, half-count fractions, clamp and gravity
    task automatic t_scale();
        load('{'{32'h57e4_0000, 32'ha81c_0000, 32'hffff_8000},
               '{32'h0001_8000, 32'h6000_1234, 32'h04e2_0000}});
        rc("gyro x word", 7'h12, 16'h57e4);
        rc("gyro y word", 7'h16, 16'ha81c);
        rc("gyro z word", 7'h1a, 16'hffff);
        rc("gyro z fraction", 7'h18, 16'h8000);
        rc("accel x fraction", 7'h1c, 16'h8000);
        rc("accel y word", 7'h22, 16'h57e4);
        rc("accel y fraction", 7'h20, 16'h0000);
        rc("accel z word", 7'h26, 16'h04e2);
    endtask

    // other page hides data, read-only and unmapped places
    task automatic t_page();
        ior_host_model_i.wr(7'h00, 16'h0001);
        rc("page", 7'h00, 16'h0001);
        rc("gyro x off page", 7'h12, 16'h0000);
        rc("unmapped", 7'h7e, 16'h0000);
        ior_host_model_i.wr(7'h00, 16'h0000);
        ior_host_model_i.wr(7'h12, 16'h1234);
        rc("gyro x read-only", 7'h12, 16'h57e4);
    endtask

    // back-to-back samples, both words from the later one
    task automatic t_coherent();
        @(posedge core_clk);
        sampleValid <= 1'b1;
        sampleIn    <= {32'h1111_2222, 160'h0};
        @(posedge core_clk);
        sampleIn    <= {32'h3333_4444, 160'h0};
        @(posedge core_clk);
        sampleValid <= 1'b0;
        rc("gyro x fraction", 7'h10, 16'h4444);
        rc("gyro x word", 7'h12, 16'h3333);
    endtask

    // clamp on both extremes, fractions cleared
    task automatic t_clamp();
        load('{'{32'h1234_5678, 32'h7fff_ffff, 32'h8000_0001},
               '{32'h9000_0000, 32'h0000_0000, 32'ha81b_ffff}});
        rc("gyro x fraction", 7'h10, 16'h5678);
        rc("gyro y word", 7'h16, 16'h57e4);
        rc("gyro y fraction", 7'h14, 16'h0000);
        rc("gyro z word", 7'h1a, 16'ha81c);
        rc("gyro z fraction", 7'h18, 16'h0000);
        rc("accel x word", 7'h1e, 16'ha81c);
        rc("accel y word", 7'h22, 16'h0000);
        rc("accel z word", 7'h26, 16'ha81c);
        rc("accel z fraction", 7'h24, 16'h0000);
    endtask

    // clock enable low: sample and page write both ignored
    task automatic t_freeze();
        @(posedge core_clk);
        clkEn <= 1'b0;
        load({32'h5555_6666, 160'h0});
        ior_host_model_i.wr(7'h00, 16'h0005);
        @(posedge core_clk);
        clkEn <= 1'b1;
        rc("page frozen", 7'h00, 16'h0000);
        rc("gyro x frozen", 7'h12, 16'h3333);
    endtask

    // reset again in mid-run: page and stored data back to zero
    task automatic t_rerun();
        ior_host_model_i.wr(7'h00, 16'h0007);
        rc("page before reset", 7'h00, 16'h0007);
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk("pageSelect after reset", 16'h0000, pageSelect);
        rc("gyro x after reset", 7'h12, 16'h0000);
    endtask

    // reset, then scenarios in order
    initial begin
        rstn        = 1'b0;
        clkEn       = 1'b1;
        sampleValid = 1'b0;
        sampleIn    = '0;
        fails       = 0;
        checks      = 0;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        t_reset();
        t_map();
        t_scale();
        t_page();
        t_clamp();
        t_coherent();
        t_freeze();
        t_rerun();
        report_and_stop();
    end

    // watchdog
    initial begin
        #100000;
        fails++;
        report_and_stop();
    end
endmodule
